// File: hdl/ddu_update_ctrl.sv
// update control for two double-buffered output channels
// assumes apb master on clk_sys; timer and pin inputs are asynchronous
`timescale 1ns/100ps
`default_nettype none
module ddu_update_ctrl
  import ddu_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic interval_timer_out,
  input wire logic ext_update_n,
  output logic [11:0] analog_out_chan0,
  output logic [11:0] analog_out_chan1,
  output logic [11:0] analog_out_chan0_bin,
  output logic [11:0] analog_out_chan1_bin,
  output logic twos_complement_code_sel,
  output logic update_irq
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // offset-binary view of a code for the converter core
  function automatic logic [11:0] to_bin(input logic [11:0] code,
                                         input logic twos);
    to_bin = twos ? (code ^ MIDSCALE) : code;
  endfunction : to_bin

  // byte-lane merge of a 12-bit holding value
  function automatic logic [11:0] merge12(input logic [11:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] st);
    merge12 = old;
    if (st[0]) merge12[7:0] = wd[7:0];
    if (st[1]) merge12[11:8] = wd[11:8];
  endfunction : merge12

  // sign-extend a channel code for read back in two's complement, zero-extend it in binary
  function automatic logic [31:0] rd_code(input logic [11:0] code,
                                          input logic twos);
    rd_code = twos ? {{20{code[11]}}, code} : {20'h00000, code};
  endfunction : rd_code

  ////////////////////////////////////////////////////////////////////////
  // synchronisers for the two update sources

  logic tmr_level;
  logic tmr_rise;
  logic ext_level;
  logic ext_rise;

  ddu_sync u_sync_tmr (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(interval_timer_out),
    .level(tmr_level),
    .rise(tmr_rise)
  );

  ddu_sync u_sync_ext (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(ext_update_n),
    .level(ext_level),
    .rise(ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic upd_low;
  logic upd_rise;

  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign addr_ok = (paddr == OFF_CHAN0) || (paddr == OFF_CHAN1) ||
                   (paddr == OFF_CTRL) || (paddr == OFF_STATUS) ||
                   (paddr == OFF_CLEAR) || (paddr == OFF_OUT0) ||
                   (paddr == OFF_OUT1);
  // a low level on either source requests a transfer
  assign upd_low = ~tmr_level | ~ext_level;
  assign upd_rise = tmr_rise | ext_rise;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  ////////////////////////////////////////////////////////////////////////
  // register state

  logic [11:0] hold0_reg;
  logic [11:0] hold0_next;
  logic [11:0] hold1_reg;
  logic [11:0] hold1_next;
  logic [11:0] out0_reg;
  logic [11:0] out0_next;
  logic [11:0] out1_reg;
  logic [11:0] out1_next;
  logic [3:0] ctrl_reg;
  logic [3:0] ctrl_next;
  logic evt_reg;
  logic evt_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [11:0] bin0_reg;
  logic [11:0] bin0_next;
  logic [11:0] bin1_reg;
  logic [11:0] bin1_next;
  logic irq_reg;
  logic irq_next;

  // holding registers, latches, control and flag
  always_comb begin
    hold0_next = hold0_reg;
    hold1_next = hold1_reg;
    ctrl_next = ctrl_reg;
    if (wr_acc && paddr == OFF_CHAN0) begin
      hold0_next = merge12(hold0_reg, pwdata, pstrb);
    end
    if (wr_acc && paddr == OFF_CHAN1) begin
      hold1_next = merge12(hold1_reg, pwdata, pstrb);
    end
    if (wr_acc && paddr == OFF_CTRL && pstrb[0]) begin
      ctrl_next = pwdata[3:0];
    end
    // output latches only follow the selected method
    out0_next = out0_reg;
    out1_next = out1_reg;
    if (!ctrl_reg[CTRL_DEF0]) begin
      out0_next = hold0_next;
    end else if (upd_low) begin
      out0_next = hold0_reg;
    end
    if (!ctrl_reg[CTRL_DEF1]) begin
      out1_next = hold1_next;
    end else if (upd_low) begin
      out1_next = hold1_reg;
    end
    // set wins over a clear in the same cycle
    evt_next = evt_reg;
    if (wr_acc && paddr == OFF_CLEAR && pstrb[0] && pwdata[STAT_EVT]) begin
      evt_next = 1'b0;
    end
    if (upd_rise) begin
      evt_next = 1'b1;
    end
    irq_next = evt_next & ctrl_next[CTRL_IRQEN];
    // converter view follows the coding select
    bin0_next = to_bin(out0_next, ctrl_next[CTRL_TWOS]);
    bin1_next = to_bin(out1_next, ctrl_next[CTRL_TWOS]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold0_reg <= CODE_RESET;
      hold1_reg <= CODE_RESET;
      out0_reg <= CODE_RESET;
      out1_reg <= CODE_RESET;
      ctrl_reg <= CTRL_RESET;
      evt_reg <= 1'b0;
      bin0_reg <= CODE_RESET;
      bin1_reg <= CODE_RESET;
      irq_reg <= 1'b0;
    end else begin
      hold0_reg <= hold0_next;
      hold1_reg <= hold1_next;
      out0_reg <= out0_next;
      out1_reg <= out1_next;
      ctrl_reg <= ctrl_next;
      evt_reg <= evt_next;
      bin0_reg <= bin0_next;
      bin1_reg <= bin1_next;
      irq_reg <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, registered at the setup phase

  always_comb begin
    rdata_next = rdata_reg;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        OFF_CHAN0: rdata_next = rd_code(hold0_reg, ctrl_reg[CTRL_TWOS]);
        OFF_CHAN1: rdata_next = rd_code(hold1_reg, ctrl_reg[CTRL_TWOS]);
        OFF_CTRL: rdata_next = {28'h0000000, ctrl_reg};
        OFF_STATUS: rdata_next = {31'h00000000, evt_reg};
        OFF_OUT0: rdata_next = rd_code(out0_reg, ctrl_reg[CTRL_TWOS]);
        OFF_OUT1: rdata_next = rd_code(out1_reg, ctrl_reg[CTRL_TWOS]);
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign prdata = rd_acc ? rdata_reg : 32'h00000000;
  assign analog_out_chan0 = out0_reg;
  assign analog_out_chan1 = out1_reg;
  assign analog_out_chan0_bin = bin0_reg;
  assign analog_out_chan1_bin = bin1_reg;
  assign twos_complement_code_sel = ctrl_reg[CTRL_TWOS];
  assign update_irq = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_imm0;
    @(posedge clk_sys) disable iff (rst)
      (wr_acc && paddr == OFF_CHAN0 && pstrb == 4'hF &&
       !ctrl_reg[CTRL_DEF0]) |=> (out0_reg == $past(pwdata[11:0]));
  endproperty
  a_imm0: assert property (p_imm0)
    else $error("chan0 immediate update missed");

  property p_hold0;
    @(posedge clk_sys) disable iff (rst)
      (ctrl_reg[CTRL_DEF0] && !upd_low) |=> $stable(out0_reg);
  endproperty
  a_hold0: assert property (p_hold0)
    else $error("chan0 latch moved without update level");

  property p_def0;
    @(posedge clk_sys) disable iff (rst)
      (ctrl_reg[CTRL_DEF0] && upd_low) |=> (out0_reg == $past(hold0_reg));
  endproperty
  a_def0: assert property (p_def0)
    else $error("chan0 deferred update missed");

  property p_def1;
    @(posedge clk_sys) disable iff (rst)
      (ctrl_reg[CTRL_DEF1] && upd_low) |=> (out1_reg == $past(hold1_reg));
  endproperty
  a_def1: assert property (p_def1)
    else $error("chan1 deferred update missed");

  property p_imm1;
    @(posedge clk_sys) disable iff (rst)
      (wr_acc && paddr == OFF_CHAN1 && pstrb == 4'hF &&
       !ctrl_reg[CTRL_DEF1]) |=> (out1_reg == $past(pwdata[11:0]));
  endproperty
  a_imm1: assert property (p_imm1)
    else $error("chan1 immediate update missed");

  property p_iso;
    @(posedge clk_sys) disable iff (rst)
      (wr_acc && paddr == OFF_CHAN1) |=> $stable(hold0_reg);
  endproperty
  a_iso: assert property (p_iso)
    else $error("chan1 write disturbed chan0");

  property p_hold1;
    @(posedge clk_sys) disable iff (rst)
      (ctrl_reg[CTRL_DEF1] && !upd_low) |=> $stable(out1_reg);
  endproperty
  a_hold1: assert property (p_hold1)
    else $error("chan1 latch moved without update level");

  // update edge, then flag up, then irq following the enable
  sequence s_edge_seen;
    upd_rise;
  endsequence

  sequence s_flag_then_irq;
    evt_reg ##1 (irq_reg == ctrl_reg[CTRL_IRQEN] || !evt_reg);
  endsequence

  property p_evt;
    @(posedge clk_sys) disable iff (rst)
      s_edge_seen |=> s_flag_then_irq;
  endproperty
  a_evt: assert property (p_evt)
    else $error("update edge did not set flag");

  property p_irq;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |=> (irq_reg == (evt_reg && ctrl_reg[CTRL_IRQEN]));
  endproperty
  a_irq: assert property (p_irq)
    else $error("irq not matching flag and enable");

  property p_sticky;
    @(posedge clk_sys) disable iff (rst)
      (evt_reg && !(wr_acc && paddr == OFF_CLEAR)) |=> evt_reg;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag dropped without clear");

  property p_bin;
    @(posedge clk_sys) disable iff (rst)
      1'b1 |-> (bin0_reg == {out0_reg[11] ^ twos_complement_code_sel,
                             out0_reg[10:0]}) &&
               (bin1_reg == {out1_reg[11] ^ twos_complement_code_sel,
                             out1_reg[10:0]});
  endproperty
  a_bin: assert property (p_bin)
    else $error("coding view wrong");

endmodule : ddu_update_ctrl
`default_nettype wire

// File: hdl/ddu_pkg.sv
// constants for the dual output channel update control block
// assumes a 32-bit apb master and a 10 MHz system clock
//
// Overview of operation
// - two 12-bit channels, each written separately
// - holding register feeds output latch, on the same edge or on update
// - chan0 select low: update on write
// - chan0 select high: update on low timer or pin level
// - chan1 select works the same way
// - select clear: straight binary, 0800 midscale
// - select set: two's complement, sign-extended
// - rising edge of either source sets flag
// - irq when flag and enable both high
package ddu_pkg;
  localparam int CODE_W = 12;
  // register byte offsets
  localparam logic [7:0] OFF_CHAN0 = 8'h00;
  localparam logic [7:0] OFF_CHAN1 = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_CLEAR = 8'h10;
  localparam logic [7:0] OFF_OUT0 = 8'h14;
  localparam logic [7:0] OFF_OUT1 = 8'h18;
  // control bit positions
  localparam int CTRL_DEF0 = 0;
  localparam int CTRL_DEF1 = 1;
  localparam int CTRL_TWOS = 2;
  localparam int CTRL_IRQEN = 3;
  // status and clear bit position
  localparam int STAT_EVT = 0;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [11:0] MIDSCALE = 12'h800;
endpackage : ddu_pkg

// File: hdl/ddu_sync.sv
// two-stage synchroniser with a rising-edge detector
// assumes the input is an asynchronous pin, resting high
`timescale 1ns/100ps
`default_nettype none
module ddu_sync (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic pin_in,
  output logic level,
  output logic rise
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;
  logic prev_reg;
  logic prev_next;

  // next values; only sync_reg reads meta_reg
  always_comb begin
    meta_next = pin_in;
    sync_next = meta_reg;
    prev_next = sync_reg;
  end

  // resting level is high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
    end
  end

  assign level = sync_reg;
  assign rise = sync_reg & ~prev_reg;
endmodule : ddu_sync
`default_nettype wire

// File: bench/ddu_pulse_src.sv
// behavioural source of update pulses on the timer and pin lines
// assumes the bench raises a request for one clk_sys cycle
`timescale 1ns/100ps
`default_nettype none
module ddu_pulse_src #(
  parameter int LOW_CYC = 4
) (
  input wire logic clk_sys,
  input wire logic go_timer,
  input wire logic go_pin,
  output logic interval_timer_out,
  output logic ext_update_n
);
  int cnt_t = 0;
  int cnt_p = 0;
  // low spans counted down on each clock
  always @(posedge clk_sys) begin
    if (go_timer) cnt_t <= LOW_CYC;
    else if (cnt_t > 0) cnt_t <= cnt_t - 1;
    if (go_pin) cnt_p <= LOW_CYC;
    else if (cnt_p > 0) cnt_p <= cnt_p - 1;
  end
  // timer line held high while idle, as software forces it
  assign interval_timer_out = (cnt_t == 0);
  // pin rests at its pull-up level between pulses
  assign ext_update_n = (cnt_p == 0);
endmodule : ddu_pulse_src
`default_nettype wire

// File: bench/tb_dual_dac_update_control.sv
// self-checking bench for the dual channel update control
// assumes zero-wait apb slave and a pulse source on the update lines
`timescale 1ns/100ps
`default_nettype none
module tb_dual_dac_update_control;
  import ddu_pkg::*;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, se;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, tmp, seed = 32'h0000000F;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, itim, extn, twos_sel, irq, t, go_t = 0, go_p = 0;
  logic [11:0] o0, o1, b0, b1, c0, c1, code;
  int errors = 0, total_checks = 0;
  ddu_update_ctrl uut (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interval_timer_out(itim), .ext_update_n(extn),
    .analog_out_chan0(o0), .analog_out_chan1(o1),
    .analog_out_chan0_bin(b0), .analog_out_chan1_bin(b1),
    .twos_complement_code_sel(twos_sel), .update_irq(irq));
  ddu_pulse_src src (.clk_sys(clk_sys), .go_timer(go_t), .go_pin(go_p),
    .interval_timer_out(itim), .ext_update_n(extn));
  always #50 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////
  // xorshift stream for random codes
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // converter view and readback of a code
  // signed code shown offset: only the sign bit flips
  function automatic logic [11:0] bin_of(input logic [11:0] c, input logic m);
    return m ? {~c[11], c[10:0]} : c;
  endfunction : bin_of
  // signed readback spans -2048 to +2047
  function automatic logic [31:0] rb_of(input logic [11:0] c, input logic m);
    int v;
    v = int'(c);
    if (m && c[11]) v = v - 4096;
    return v;
  endfunction : rb_of
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer, request held until pready seen
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task outs(input logic m);
    chk("out0", {20'h0, c0}, {20'h0, o0});
    chk("out1", {20'h0, c1}, {20'h0, o1});
    chk("bin0", {20'h0, bin_of(c0, m)}, {20'h0, b0});
    chk("bin1", {20'h0, bin_of(c1, m)}, {20'h0, b1});
  endtask : outs
  // one low pulse on the timer or the pin, then settle
  task fire(input logic tmr);
    if (tmr) go_t <= 1'b1;
    else go_p <= 1'b1;
    @(posedge clk_sys);
    go_t <= 1'b0;
    go_p <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask : fire
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial begin
    #(3000 * 100);
    errors++;
    end_of_test();
  end
  // main sequence
  initial begin
    c0 = CODE_RESET;
    c1 = CODE_RESET;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl", {28'h0, CTRL_RESET}, q);
    outs(1'b0);
    $display("test reset done");
    // immediate writes in both codings, corner codes first
    for (int i = 0; i < 8; i++) begin
      t = i[2];
      tmp = rnd();
      code = (i == 0) ? 12'hFFF : (i == 4) ? MIDSCALE : tmp[11:0];
      if (i[0]) c1 = code;
      else c0 = code;
      apb(1'b1, OFF_CTRL, {29'h0, t, 2'b00});
      apb(1'b1, i[0] ? OFF_CHAN1 : OFF_CHAN0, {20'h0, code});
      outs(t);
      apb(1'b0, i[0] ? OFF_OUT1 : OFF_OUT0, 32'h0);
      chk("readback", rb_of(code, t), q);
      chk("twos sel", {31'h0, t}, {31'h0, twos_sel});
    end
    $display("test immediate done");
    // deferred on both channels, enable last
    apb(1'b1, OFF_CTRL, 32'h3);
    apb(1'b1, OFF_CTRL, 32'hB);
    tmp = rnd();
    apb(1'b1, OFF_CHAN0, {20'h0, tmp[11:0]});
    apb(1'b1, OFF_CHAN1, {20'h0, tmp[23:12]});
    outs(1'b0);
    c0 = tmp[11:0];
    c1 = tmp[23:12];
    fire(1'b0);
    outs(1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("flag", 32'h1, q);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_CTRL, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("flag", 32'h1, q);
    apb(1'b1, OFF_CLEAR, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("flag", 32'h0, q);
    $display("test pin update done");
    // timer driven update of channel zero only
    tmp = rnd();
    apb(1'b1, OFF_CHAN0, {20'h0, tmp[11:0]});
    outs(1'b0);
    c0 = tmp[11:0];
    fire(1'b1);
    outs(1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("flag", 32'h1, q);
    $display("test timer update done");
    // low byte lane only, bits above the code ignored
    tmp = rnd();
    apb(1'b1, OFF_CTRL, 32'h0);
    pstrb <= 4'h1;
    apb(1'b1, OFF_CHAN1, tmp);
    pstrb <= 4'hF;
    c1[7:0] = tmp[7:0];
    outs(1'b0);
    $display("test byte lane done");
    // unmapped address refused
    apb(1'b0, 8'h1C, 32'h0);
    chk("slverr", 32'h1, {31'h0, se});
    chk("unmapped", 32'h0, q);
    $display("test unmapped done");
    end_of_test();
  end
endmodule : tb_dual_dac_update_control
`default_nettype wire
